//--- src/ptd_top.sv
// ptd_top: pulse timer, one-tick delay cell and latch stage with axi4-lite registers
// assumes process pins are asynchronous and the bus master runs on mclk
`timescale 1ns/1ps
module ptd_top
  import ptd_pkg::*;
#(
  parameter int unsigned ADDR_W       = 8,
  parameter int unsigned VAL_W        = 16,
  parameter logic [15:0] CONST_VALUE  = 16'h0032,
  parameter logic [1:0]  CONST_BASE   = 2'b00,
  parameter int unsigned P_TICKS_B0   = TICKS_B0,
  parameter int unsigned P_TICKS_B1   = TICKS_B1,
  parameter int unsigned P_TICKS_B2   = TICKS_B2
) (
  input  wire logic              mclk,
  input  wire logic              rstn,
  input  wire logic              start_in,
  input  wire logic              reset_in,
  input  wire logic              delay_d_in,
  input  wire logic              latch_set_in,
  input  wire logic              latch_clr_in,
  output logic                   timer_q_out,
  output logic                   delay_q_out,
  output logic                   latch_q_out,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready
);
  localparam int unsigned NSYNC = 5;
  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [NSYNC-1:0] sync1_q;
  logic [NSYNC-1:0] sync2_q;
  logic             start_s;
  logic             reset_s;
  logic             dly_s;
  logic             lset_s;
  logic             lclr_s;
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      sync1_q <= '0;
      sync2_q <= '0;
    end else begin
      sync1_q <= {latch_clr_in, latch_set_in, delay_d_in, reset_in, start_in};
      sync2_q <= sync1_q;
    end
  end
  assign {lclr_s, lset_s, dly_s, reset_s, start_s} = sync2_q;
  // ----------------------------------------------------------------
  // tick divider
  // ----------------------------------------------------------------
  logic [7:0] tick_cnt_q;
  logic [7:0] tick_cnt_d;
  logic       tick;
  assign tick = (tick_cnt_q == 8'(TICK_CYC - 1));
  always_comb begin
    tick_cnt_d = tick ? 8'h00 : tick_cnt_q + 8'h01;
  end
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) tick_cnt_q <= 8'h00;
    else       tick_cnt_q <= tick_cnt_d;
  end
  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [31:0] ctrl_q;
  logic [31:0] ctrl_d;
  logic [31:0] param_q;
  logic [31:0] param_d;
  logic        running_q;
  logic        running_d;
  logic        latch_d;
  logic        dly_int;
  // ----------------------------------------------------------------
  // preset selection
  // ----------------------------------------------------------------
  logic [VAL_W-1:0] preset_val;
  logic [1:0]       preset_base;
  logic [23:0]      unit_ticks;
  always_comb begin
    if (ctrl_q[CTRL_SEL]) begin
      preset_val  = VAL_W'(param_q[PARAM_VAL_HI:PARAM_VAL_LO]);
      preset_base = param_q[PARAM_BASE_LO+1:PARAM_BASE_LO];
    end else begin
      preset_val  = VAL_W'(CONST_VALUE);
      preset_base = CONST_BASE;
    end
    case (ptd_base_e'(preset_base))
      PTD_BASE_MS: unit_ticks = 24'(TICKS_MS);
      PTD_BASE_B0: unit_ticks = 24'(P_TICKS_B0);
      PTD_BASE_B1: unit_ticks = 24'(P_TICKS_B1);
      PTD_BASE_B2: unit_ticks = 24'(P_TICKS_B2);
      default:     unit_ticks = 24'(TICKS_MS);
    endcase
  end
  // ----------------------------------------------------------------
  // pulse timer
  // ----------------------------------------------------------------
  logic             start_prev_q;
  logic [23:0]      unit_cnt_q;
  logic [23:0]      unit_cnt_d;
  logic [VAL_W-1:0] remain_q;
  logic [VAL_W-1:0] remain_d;
  logic             timer_out_d;
  always_comb begin
    running_d  = running_q;
    unit_cnt_d = unit_cnt_q;
    remain_d   = remain_q;
    if (start_s && !start_prev_q) begin
      running_d  = (preset_val != '0);
      unit_cnt_d = 24'h00_0000;
      remain_d   = preset_val;
    end else if (running_q && tick) begin
      if (unit_cnt_q >= unit_ticks - 24'h00_0001) begin
        unit_cnt_d = 24'h00_0000;
        remain_d   = remain_q - VAL_W'(1);
        if (remain_q <= VAL_W'(1)) running_d = 1'b0;
      end else begin
        unit_cnt_d = unit_cnt_q + 24'h00_0001;
      end
    end
    if (!start_s || reset_s) running_d = 1'b0;
    timer_out_d = running_d && start_s && !reset_s;
  end
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      start_prev_q <= 1'b0;
      running_q    <= 1'b0;
      unit_cnt_q   <= 24'h00_0000;
      remain_q     <= '0;
      timer_q_out  <= 1'b0;
    end else begin
      start_prev_q <= start_s;
      running_q    <= running_d;
      unit_cnt_q   <= unit_cnt_d;
      remain_q     <= remain_d;
      timer_q_out  <= timer_out_d;
    end
  end
  // ----------------------------------------------------------------
  // latch stage and delay cell
  // ----------------------------------------------------------------
  always_comb begin
    latch_d = latch_q_out;
    if (tick) begin
      if (lclr_s)      latch_d = 1'b0;
      else if (lset_s) latch_d = 1'b1;
    end
  end
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      latch_q_out <= 1'b0;
    end else begin
      latch_q_out <= latch_d;
    end
  end
  ptd_delay_cell u_one_tick_delay_cell (
    .mclk    (mclk),
    .rstn    (rstn),
    .tick    (tick),
    .d       (dly_s),
    .inv_in  (ctrl_q[CTRL_INV_IN]),
    .inv_out (ctrl_q[CTRL_INV_OUT]),
    .q_int   (dly_int),
    .q_pin   (delay_q_out)
  );
  // ----------------------------------------------------------------
  // axi4-lite slave
  // ----------------------------------------------------------------
  logic              aw_have_q, aw_have_d, w_have_q, w_have_d;
  logic [ADDR_W-1:0] waddr_q, waddr_d;
  logic [31:0]       wdata_q, wdata_d;
  logic [3:0]        wstrb_q, wstrb_d;
  logic              bvalid_d, rvalid_d, awready_d, wready_d, arready_d;
  logic [1:0]        bresp_d, rresp_d;
  logic [31:0]       rdata_d;
  logic [31:0]       wmask;
  always_comb begin
    aw_have_d = aw_have_q;
    w_have_d  = w_have_q;
    waddr_d   = waddr_q;
    wdata_d   = wdata_q;
    wstrb_d   = wstrb_q;
    bvalid_d  = s_axi_bvalid && !s_axi_bready;
    bresp_d   = s_axi_bresp;
    ctrl_d    = ctrl_q;
    param_d   = param_q;
    wmask     = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}}, {8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
    if (s_axi_awvalid && s_axi_awready) begin
      aw_have_d = 1'b1;
      waddr_d   = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      w_have_d = 1'b1;
      wdata_d  = s_axi_wdata;
      wstrb_d  = s_axi_wstrb;
    end
    if (aw_have_q && w_have_q && !s_axi_bvalid) begin
      aw_have_d = 1'b0;
      w_have_d  = 1'b0;
      bvalid_d  = 1'b1;
      bresp_d   = RESP_OKAY;
      case (8'(waddr_q))
        OFS_CTRL:   ctrl_d  = (ctrl_q & ~wmask) | (wdata_q & wmask);
        OFS_PARAM:  param_d = (param_q & ~wmask) | (wdata_q & wmask);
        OFS_STATUS: bresp_d = RESP_SLVERR;
        default:    bresp_d = RESP_SLVERR;
      endcase
    end
    awready_d = !aw_have_d && !bvalid_d;
    wready_d  = !w_have_d && !bvalid_d;
    rvalid_d  = s_axi_rvalid && !s_axi_rready;
    rdata_d   = s_axi_rdata;
    rresp_d   = s_axi_rresp;
    if (s_axi_arvalid && s_axi_arready) begin
      rvalid_d = 1'b1;
      rresp_d  = RESP_OKAY;
      rdata_d  = 32'h0000_0000;
      case (8'(s_axi_araddr))
        OFS_CTRL:   rdata_d = ctrl_q;
        OFS_PARAM:  rdata_d = param_q;
        OFS_STATUS: begin
          rdata_d[STAT_RUN]   = running_q;
          rdata_d[STAT_OUT]   = timer_q_out;
          rdata_d[STAT_DLY]   = dly_int;
          rdata_d[STAT_LATCH] = latch_q_out;
        end
        default:    rresp_d = RESP_SLVERR;
      endcase
    end
    arready_d = !rvalid_d;
  end
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      aw_have_q     <= 1'b0;
      w_have_q      <= 1'b0;
      waddr_q       <= '0;
      wdata_q       <= 32'h0000_0000;
      wstrb_q       <= 4'h0;
      ctrl_q        <= CTRL_RST;
      param_q       <= PARAM_RST;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= RESP_OKAY;
    end else begin
      aw_have_q     <= aw_have_d;
      w_have_q      <= w_have_d;
      waddr_q       <= waddr_d;
      wdata_q       <= wdata_d;
      wstrb_q       <= wstrb_d;
      ctrl_q        <= ctrl_d;
      param_q       <= param_d;
      s_axi_awready <= awready_d;
      s_axi_wready  <= wready_d;
      s_axi_bvalid  <= bvalid_d;
      s_axi_bresp   <= bresp_d;
      s_axi_arready <= arready_d;
      s_axi_rvalid  <= rvalid_d;
      s_axi_rdata   <= rdata_d;
      s_axi_rresp   <= rresp_d;
    end
  end
endmodule // ptd_top

//--- src/ptd_pkg.sv
// ptd_pkg: constants shared by the pulse timer and delay cell block
// assumes a 25 MHz mclk and an axi4-lite register bus with 32-bit data
package ptd_pkg;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_NS      = 40;
  localparam int unsigned TICK_NS     = 7800;
  localparam int unsigned TICK_CYC    = TICK_NS / CLK_NS;
  localparam int unsigned UNIT_MS_NS  = 1000000;
  localparam int unsigned UNIT_B0_NS  = 10000000;
  localparam int unsigned UNIT_B1_NS  = 100000000;
  localparam int unsigned UNIT_B2_NS  = 1000000000;
  localparam int unsigned TICKS_MS    = UNIT_MS_NS / TICK_NS;
  localparam int unsigned TICKS_B0    = UNIT_B0_NS / TICK_NS;
  localparam int unsigned TICKS_B1    = UNIT_B1_NS / TICK_NS;
  localparam int unsigned TICKS_B2    = UNIT_B2_NS / TICK_NS;

  // ----------------------------------------------------------------
  // time base codes
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    PTD_BASE_MS = 2'b00,
    PTD_BASE_B0 = 2'b01,
    PTD_BASE_B1 = 2'b10,
    PTD_BASE_B2 = 2'b11
  } ptd_base_e;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [7:0]  OFS_CTRL     = 8'h00;
  localparam logic [7:0]  OFS_PARAM    = 8'h04;
  localparam logic [7:0]  OFS_STATUS   = 8'h08;
  localparam int unsigned CTRL_SEL     = 0;
  localparam int unsigned CTRL_INV_IN  = 4;
  localparam int unsigned CTRL_INV_OUT = 5;
  localparam int unsigned PARAM_VAL_LO = 0;
  localparam int unsigned PARAM_VAL_HI = 15;
  localparam int unsigned PARAM_BASE_LO = 16;
  localparam int unsigned STAT_RUN     = 0;
  localparam int unsigned STAT_OUT     = 1;
  localparam int unsigned STAT_DLY     = 2;
  localparam int unsigned STAT_LATCH   = 3;
  localparam logic [31:0] CTRL_RST     = 32'h0000_0000;
  localparam logic [31:0] PARAM_RST    = 32'h0000_0000;
  localparam logic [1:0]  RESP_OKAY    = 2'b00;
  localparam logic [1:0]  RESP_SLVERR  = 2'b10;

endpackage

//--- src/ptd_delay_cell.sv
// ptd_delay_cell: one-tick delay with optional input and output inversion
// assumes tick is a one-cycle pulse on mclk and d is already synchronous
`timescale 1ns/1ps
module ptd_delay_cell
  import ptd_pkg::*;
(
  input  wire logic mclk,
  input  wire logic rstn,
  input  wire logic tick,
  input  wire logic d,
  input  wire logic inv_in,
  input  wire logic inv_out,
  output logic      q_int,
  output logic      q_pin
);

  logic q_int_d;
  logic q_pin_d;

  // ----------------------------------------------------------------
  // delay stage
  // ----------------------------------------------------------------
  always_comb begin
    q_int_d = q_int;
    q_pin_d = q_pin;
    if (tick) begin
      q_int_d = d ^ inv_in;
      q_pin_d = d ^ inv_in ^ inv_out;
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      q_int <= 1'b0;
      q_pin <= 1'b0;
    end else begin
      q_int <= q_int_d;
      q_pin <= q_pin_d;
    end
  end

endmodule // ptd_delay_cell

//--- testbench/ptd_proc_model.sv
// ptd_proc_model: process side, turns bench pin commands into pin levels
// assumes commands change right after a rising mclk edge
`timescale 1ns/1ps
module ptd_proc_model (
  input  wire logic       mclk,
  input  wire logic [4:0] cmd,
  output logic            start_in,
  output logic            reset_in,
  output logic            delay_d_in,
  output logic            latch_set_in,
  output logic            latch_clr_in
);
  // ----------------------------------------------------------------
  // pins move off the clock edge, like a real process input
  // ----------------------------------------------------------------
  initial {latch_clr_in, latch_set_in, delay_d_in, reset_in, start_in} = 5'h00;
  // start, reset, delay and latch pins in parallel paths
  always @(posedge mclk)
    {latch_clr_in, latch_set_in, delay_d_in, reset_in, start_in} <= #7 cmd;
endmodule // ptd_proc_model

//--- testbench/ptd_top_props.sv
// ptd_top_props: port checker for ptd_top
// assumes one mclk domain with active-low asynchronous rstn
`timescale 1ns/1ps
module ptd_top_props
  import ptd_pkg::*;
(
  input wire logic       mclk,
  input wire logic       rstn,
  input wire logic       start_in,
  input wire logic       reset_in,
  input wire logic       latch_clr_in,
  input wire logic       timer_q_out,
  input wire logic       delay_q_out,
  input wire logic       latch_q_out,
  input wire logic       s_axi_awvalid,
  input wire logic       s_axi_awready,
  input wire logic       s_axi_wvalid,
  input wire logic       s_axi_wready,
  input wire logic       s_axi_bvalid,
  input wire logic [1:0] s_axi_bresp,
  input wire logic       s_axi_arvalid,
  input wire logic       s_axi_arready,
  input wire logic       s_axi_rvalid
);
  // ----------------------------------------------------------------
  // tick grid helper
  // ----------------------------------------------------------------
  int unsigned gap_q;
  logic        seen_q, dq_q, lq_q, edg;
  logic [7:0]  clr_n_q;
  assign edg = (delay_q_out != dq_q) || (latch_q_out != lq_q);
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      gap_q  <= 0;
      seen_q <= 1'b0;
      dq_q   <= 1'b0;
      lq_q   <= 1'b0;
      clr_n_q <= 8'h00;
    end else begin
      gap_q  <= edg ? 1 : gap_q + 1;
      clr_n_q <= !latch_clr_in ? 8'h00 : clr_n_q + 8'(clr_n_q != 8'hFF);
      seen_q <= seen_q | edg;
      dq_q   <= delay_q_out;
      lq_q   <= latch_q_out;
    end
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);
  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  AST_START_LOW_STOPS: assert property (
    !start_in [*4] |-> !timer_q_out) else $error("timer high with start low");
  AST_RESET_STOPS: assert property (
    reset_in [*4] |-> !timer_q_out) else $error("timer high during reset");
  AST_OUT_CAUSE: assert property (
    $rose(timer_q_out) |-> $past(start_in, 3)) else $error("timer rose without start");
  AST_LATCH_CLR: assert property (
    clr_n_q == 8'hC8 |-> !latch_q_out) else $error("latch not cleared");
  AST_TICK_GRID: assert property (
    edg && seen_q |-> (gap_q % TICK_CYC) == 0) else $error("output change off tick");
  AST_B_LATENCY: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("write response late");
  AST_AW_BLOCK: assert property (
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready) else $error("write taken early");
  AST_R_LATENCY: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
    else $error("read answer late");
  COV_TIMER: cover property ($rose(timer_q_out));
  COV_SLVERR: cover property (s_axi_bvalid && s_axi_bresp == RESP_SLVERR);
  COV_LATCH: cover property ($rose(latch_q_out));
endmodule // ptd_top_props
bind ptd_top ptd_top_props ptd_top_props_i (.*);

//--- testbench/testbench.sv
// testbench: drives ptd_top pins and registers, checks against a bench model
// assumes ptd_proc_model sits between bench commands and the pins
`timescale 1ns/1ps
module testbench
  import ptd_pkg::*;
;
  localparam int unsigned LIMIT = 90000;
  logic        mclk, rstn, start_in, reset_in, delay_d_in, latch_set_in, latch_clr_in;
  logic        timer_q_out, delay_q_out, latch_q_out;
  logic [4:0]  cmd;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready;
  int          n_fail, checks_done, cnt, v, d;
  int          tk[4];
  logic [31:0] mdl[3];
  ptd_proc_model ptd_proc_model_i (.mclk(mclk), .cmd(cmd), .start_in(start_in),
    .reset_in(reset_in), .delay_d_in(delay_d_in), .latch_set_in(latch_set_in),
    .latch_clr_in(latch_clr_in));
  ptd_top #(.CONST_VALUE(16'h0002), .CONST_BASE(2'b01), .P_TICKS_B0(4), .P_TICKS_B1(8),
    .P_TICKS_B2(16)) ptd_top_i (.*);
  always #20 mclk = ~mclk;
  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e) begin
      n_fail++;
      $display("Error at %0t: saw %h, want %h", $time, g, e);
    end
  endtask
  task automatic conclude();
    $display("checks %0d, mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] dt, input logic [3:0] s,
                    input logic [1:0] er);
    logic ad, wd;
    ad = 0;
    wd = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= dt;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    while (!(ad && wd)) begin
      @(posedge mclk);
      if (s_axi_awvalid && s_axi_awready) begin ad = 1; s_axi_awvalid <= 0; end
      if (s_axi_wvalid && s_axi_wready) begin wd = 1; s_axi_wvalid <= 0; end
    end
    s_axi_bready <= 1;
    do @(posedge mclk); while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 0;
    chk(s_axi_bresp, er);
    for (int i = 0; i < 4; i++)
      if (er == RESP_OKAY && s[i]) mdl[a >> 2][8*i +: 8] = dt[8*i +: 8];
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    do @(posedge mclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 0;
    s_axi_rready <= 1;
    do @(posedge mclk); while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 0;
    chk(s_axi_rdata, e);
    chk(s_axi_rresp, er);
  endtask
  task automatic pulse(input int t);
    int n;
    n = 0;
    cmd[0] <= 1;
    while (timer_q_out !== 1'b1) @(posedge mclk);
    while (timer_q_out === 1'b1) begin @(posedge mclk); n++; end
    chk(32'(n >= (t-1)*TICK_CYC && n <= t*TICK_CYC+3), 1);
    cmd[0] <= 0;
    cyc(6);
  endtask
  always @(posedge mclk) begin
    cnt++;
    if (cnt == LIMIT) begin n_fail++; conclude(); end
  end
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    {mclk, rstn, cmd, n_fail, checks_done, cnt} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    tk = '{128, 4, 8, 16};
    mdl = '{CTRL_RST, PARAM_RST, 32'h0000_0000};
    void'($urandom(82));
    cyc(6);
    rstn <= 1;
    cyc(2);
    rd(OFS_CTRL, mdl[0], RESP_OKAY);
    rd(OFS_PARAM, mdl[1], RESP_OKAY);
    rd(8'h0C, 32'h0000_0000, RESP_SLVERR);
    wr(OFS_STATUS, 32'h0000_000F, 4'hF, RESP_SLVERR);
    wr(8'h0C, 32'h0000_00FF, 4'hF, RESP_SLVERR);
    rd(OFS_CTRL, mdl[0], RESP_OKAY);
    rd(OFS_STATUS, 32'h0000_0000, RESP_OKAY);
    $display("test registers done");
    pulse(2 * tk[1]);
    wr(OFS_CTRL, 32'h0000_0001, 4'hF, RESP_OKAY);
    for (int b = 0; b < 4; b++) begin
      v = (b == 0) ? 1 : 1 + $urandom % 3;
      wr(OFS_PARAM, 32'(v) | (32'(b) << 16), 4'hF, RESP_OKAY);
      rd(OFS_PARAM, mdl[1], RESP_OKAY);
      pulse(v * tk[b]);
    end
    wr(OFS_PARAM, 32'h0003_00FF, 4'h1, RESP_OKAY);
    rd(OFS_PARAM, mdl[1], RESP_OKAY);
    $display("test presets done");
    wr(OFS_PARAM, 32'h0003_0003, 4'hF, RESP_OKAY);
    cmd[0] <= 1;
    cyc(400);
    rd(OFS_STATUS, 32'h0000_0003, RESP_OKAY);
    cmd[0] <= 0;
    cyc(5);
    chk(timer_q_out, 0);
    cmd[0] <= 1;
    cyc(400);
    cmd[1] <= 1;
    cyc(5);
    chk(timer_q_out, 0);
    cmd[1] <= 0;
    cyc(400);
    chk(timer_q_out, 0);
    cmd[0] <= 0;
    $display("test stop conditions done");
    for (int i = 0; i < 8; i++) begin
      if (i % 2 == 0) wr(OFS_CTRL, 32'(i / 2) << 4, 4'hF, RESP_OKAY);
      d = (i % 2 == 0) ? $urandom % 2 : d ^ 1;
      cmd[2] <= d[0];
      cyc(2 * TICK_CYC + 4);
      chk(delay_q_out, 32'(d ^ (i / 2 % 2) ^ (i / 4)));
      rd(OFS_STATUS, 32'(d ^ (i / 2 % 2)) << 2, RESP_OKAY);
    end
    $display("test delay cell done");
    wr(OFS_CTRL, 32'h0000_0000, 4'hF, RESP_OKAY);
    cmd[2] <= 0;
    cyc(2 * TICK_CYC + 4);
    cmd[3:2] <= 2'b11;
    while (delay_q_out !== 1'b1 && latch_q_out !== 1'b1) @(posedge mclk);
    chk(latch_q_out, delay_q_out);
    cmd[4:3] <= 2'b11;
    cyc(2 * TICK_CYC + 4);
    chk(latch_q_out, 0);
    cmd <= 5'h00;
    cyc(4);
    $display("test latch alignment done");
    conclude();
  end
endmodule // testbench
